// ### iaj_pkg.sv
// Shared types and constants for the integer ALU and jump unit
package iaj_pkg;
	localparam int          WORD_W       = 32;
	localparam int          REG_IDX_W    = 5;
	localparam int          SHAMT_W      = 5;
	localparam int          IMM12_W      = 12;
	localparam int          JIMM_W       = 21;
	localparam logic [6:0]  OPC_REG      = 7'h33;
	localparam logic [6:0]  OPC_IMM      = 7'h13;
	localparam logic [6:0]  OPC_JUMP     = 7'h6F;
	localparam logic [6:0]  OPC_IND_JUMP = 7'h67;
	localparam logic [6:0]  UPPER_BASE   = 7'h00;
	localparam logic [6:0]  UPPER_ALT    = 7'h20;
	localparam logic [2:0]  F3_SUM       = 3'h0;
	localparam logic [2:0]  F3_SHL       = 3'h1;
	localparam logic [2:0]  F3_SLESS     = 3'h2;
	localparam logic [2:0]  F3_ULESS     = 3'h3;
	localparam logic [2:0]  F3_XOR       = 3'h4;
	localparam logic [2:0]  F3_SHR       = 3'h5;
	localparam logic [2:0]  F3_OR        = 3'h6;
	localparam logic [2:0]  F3_AND       = 3'h7;
	localparam logic [4:0]  REG_ZERO     = 5'h00;
	localparam logic [4:0]  LINK_MAIN    = 5'h01;
	localparam logic [4:0]  LINK_ALT     = 5'h05;
	localparam logic [31:0] INSN_STEP    = 32'h0000_0004;

	typedef enum logic [3:0] {
		IAJ_OP_NONE, IAJ_OP_SUM, IAJ_OP_DIFF, IAJ_OP_SLESS, IAJ_OP_ULESS,
		IAJ_OP_AND, IAJ_OP_OR, IAJ_OP_XOR, IAJ_OP_SHL, IAJ_OP_SHR,
		IAJ_OP_SHRA, IAJ_OP_IMM_SUM, IAJ_OP_PC_JUMP, IAJ_OP_IND_JUMP,
		IAJ_OP_ILLEGAL
	} iaj_op_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] pc;
		logic [31:0] insn;
		logic [31:0] src1;
		logic [31:0] src2;
		logic        fetch_fault;
	} iaj_req_t;

	typedef struct packed {
		logic        valid;
		logic        wr_en;
		logic [4:0]  dest_reg;
		logic [31:0] wr_data;
		logic        redirect;
		logic [31:0] target;
		logic        misaligned;
		logic        illegal;
		logic        is_nop;
		logic        ras_push;
		logic        ras_pop;
		logic [31:0] exc_pc;
		logic        fetch_fault;
	} iaj_rsp_t;
endpackage

// ### iaj_decode.sv
// Instruction decoder: opcode and function fields to operation
`timescale 1ns/1ps
`default_nettype none
module iaj_decode (
	input  wire logic [31:0]    insn,
	output iaj_pkg::iaj_op_t    op,
	output logic [31:0]         imm_i,
	output logic [31:0]         imm_j
);
	logic [6:0] opcode;
	logic [6:0] upper_func_field;
	logic [2:0] lower_func_field;

	assign opcode           = insn[6:0];
	assign upper_func_field = insn[31:25];
	assign lower_func_field = insn[14:12];
	assign imm_i = {{20{insn[31]}}, insn[31:20]};
	assign imm_j = {{12{insn[31]}}, insn[19:12], insn[20], insn[30:21], 1'b0};

	always_comb begin
		op = iaj_pkg::IAJ_OP_ILLEGAL;
		if (opcode == iaj_pkg::OPC_REG) begin
			// Both function fields select the operation
			if (upper_func_field == iaj_pkg::UPPER_BASE) begin
				case (lower_func_field)
					iaj_pkg::F3_SUM:   op = iaj_pkg::IAJ_OP_SUM;
					iaj_pkg::F3_SHL:   op = iaj_pkg::IAJ_OP_SHL;
					iaj_pkg::F3_SLESS: op = iaj_pkg::IAJ_OP_SLESS;
					iaj_pkg::F3_ULESS: op = iaj_pkg::IAJ_OP_ULESS;
					iaj_pkg::F3_XOR:   op = iaj_pkg::IAJ_OP_XOR;
					iaj_pkg::F3_SHR:   op = iaj_pkg::IAJ_OP_SHR;
					iaj_pkg::F3_OR:    op = iaj_pkg::IAJ_OP_OR;
					default:           op = iaj_pkg::IAJ_OP_AND;
				endcase
			end else if (upper_func_field == iaj_pkg::UPPER_ALT) begin
				if (lower_func_field == iaj_pkg::F3_SUM) begin
					op = iaj_pkg::IAJ_OP_DIFF;
				end else if (lower_func_field == iaj_pkg::F3_SHR) begin
					op = iaj_pkg::IAJ_OP_SHRA;
				end
			end
		end else if (opcode == iaj_pkg::OPC_IMM && lower_func_field == iaj_pkg::F3_SUM) begin
			op = iaj_pkg::IAJ_OP_IMM_SUM;
		end else if (opcode == iaj_pkg::OPC_JUMP) begin
			op = iaj_pkg::IAJ_OP_PC_JUMP;
		end else if (opcode == iaj_pkg::OPC_IND_JUMP && lower_func_field == iaj_pkg::F3_SUM) begin
			op = iaj_pkg::IAJ_OP_IND_JUMP;
		end
	end
endmodule
`default_nettype wire

// ### iaj_ras_hint.sv
// Return-stack push and pop hints from link register numbers
`timescale 1ns/1ps
`default_nettype none
module iaj_ras_hint (
	input  wire logic       is_pc_jump,
	input  wire logic       is_ind_jump,
	input  wire logic [4:0] dest_reg,
	input  wire logic [4:0] first_source_reg,
	output logic            push,
	output logic            pop
);
	logic dest_link;
	logic src_link;

	assign dest_link = (dest_reg == iaj_pkg::LINK_MAIN) || (dest_reg == iaj_pkg::LINK_ALT);
	assign src_link  = (first_source_reg == iaj_pkg::LINK_MAIN)
		|| (first_source_reg == iaj_pkg::LINK_ALT);

	always_comb begin
		push = 1'b0;
		pop  = 1'b0;
		if (is_pc_jump) begin
			push = dest_link;
		end else if (is_ind_jump) begin
			// Same link pushes only; different links pop then push
			push = dest_link;
			pop  = src_link && !(dest_link && dest_reg == first_source_reg);
		end
	end
endmodule
`default_nettype wire

// ### iaj_unit.sv
// Execute stage: register ALU operations, no-operation and jumps
// Overview of operation
// - Sum adds sources, difference subtracts second from first, low bits kept.
// - Signed and unsigned less-than write one when first below second.
// - AND, OR and XOR combine the two sources bit by bit.
// - Shifts use only low five bits of second source; arithmetic copies sign.
// - Register operations read both sources, both function fields pick the op.
// - Canonical no-operation changes no architectural state.
// - Immediate sum adds sign-extended twelve-bit immediate, overflow ignored.
// - Jumps redirect at once, no delay slot; next instruction is squashed.
// - Target fetch faults are reported against the target, not the jump.
// - Relative jump target is pc plus sign-extended halfword-scaled offset.
// - Relative jump writes pc plus four to destination.
// - Indirect target is first source plus immediate with bit zero cleared.
// - Indirect jump writes pc plus four; discarded for register zero.
// - Targets off a four-byte boundary raise misaligned exception.
// - With sixteen-bit alignment support misaligned exception never raised.
// - Relative jump pushes return stack only for link destinations.
// - Indirect jump return stack action follows link register table.
`timescale 1ns/1ps
`default_nettype none
module iaj_unit #(
	parameter int   WORD_WIDTH   = iaj_pkg::WORD_W,
	parameter bit   HALF_ALIGNED = 1'b0
) (
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire iaj_pkg::iaj_req_t req,
	output iaj_pkg::iaj_rsp_t      rsp
);
	if (WORD_WIDTH != iaj_pkg::WORD_W) begin : g_width_check
		$error("iaj_unit supports only a 32-bit word width");
	end

	iaj_pkg::iaj_op_t op;
	logic [31:0]      imm_i;
	logic [31:0]      imm_j;
	logic [4:0]       dest_reg;
	logic [4:0]       first_source_reg;
	logic [4:0]       shamt;
	logic [31:0]      result;
	logic [31:0]      target;
	logic [31:0]      ind_sum;
	logic [31:0]      link;
	logic             is_jump;
	logic             writes;
	logic             ras_push;
	logic             ras_pop;
	logic             squash_d;
	logic             squash_q;
	logic             live;
	iaj_pkg::iaj_rsp_t rsp_d;
	iaj_pkg::iaj_rsp_t rsp_q;

	assign dest_reg         = req.insn[11:7];
	assign first_source_reg = req.insn[19:15];
	assign shamt            = req.src2[4:0];

	iaj_decode u_decode (
		.insn  (req.insn),
		.op    (op),
		.imm_i (imm_i),
		.imm_j (imm_j)
	);

	iaj_ras_hint u_ras (
		.is_pc_jump       (op == iaj_pkg::IAJ_OP_PC_JUMP),
		.is_ind_jump      (op == iaj_pkg::IAJ_OP_IND_JUMP),
		.dest_reg         (dest_reg),
		.first_source_reg (first_source_reg),
		.push             (ras_push),
		.pop              (ras_pop)
	);

	assign link    = req.pc + iaj_pkg::INSN_STEP;
	assign ind_sum = req.src1 + imm_i;
	assign is_jump = (op == iaj_pkg::IAJ_OP_PC_JUMP) || (op == iaj_pkg::IAJ_OP_IND_JUMP);

	always_comb begin
		target = req.pc + imm_j;
		if (op == iaj_pkg::IAJ_OP_IND_JUMP) begin
			target = {ind_sum[31:1], 1'b0};
		end
	end

	always_comb begin
		result = '0;
		writes = 1'b1;
		case (op)
			iaj_pkg::IAJ_OP_SUM:      result = req.src1 + req.src2;
			iaj_pkg::IAJ_OP_DIFF:     result = req.src1 - req.src2;
			iaj_pkg::IAJ_OP_SLESS:    result = {31'h0000_0000, $signed(req.src1) < $signed(req.src2)};
			iaj_pkg::IAJ_OP_ULESS:    result = {31'h0000_0000, req.src1 < req.src2};
			iaj_pkg::IAJ_OP_AND:      result = req.src1 & req.src2;
			iaj_pkg::IAJ_OP_OR:       result = req.src1 | req.src2;
			iaj_pkg::IAJ_OP_XOR:      result = req.src1 ^ req.src2;
			iaj_pkg::IAJ_OP_SHL:      result = req.src1 << shamt;
			iaj_pkg::IAJ_OP_SHR:      result = req.src1 >> shamt;
			iaj_pkg::IAJ_OP_SHRA:     result = $unsigned($signed(req.src1) >>> shamt);
			iaj_pkg::IAJ_OP_IMM_SUM:  result = req.src1 + imm_i;
			iaj_pkg::IAJ_OP_PC_JUMP,
			iaj_pkg::IAJ_OP_IND_JUMP: result = link;
			default:                  writes = 1'b0;
		endcase
	end

	// Instruction right behind a taken jump is dropped
	assign live = req.valid && !squash_q;

	always_comb begin
		squash_d = 1'b0;
		if (live) begin
			// Exceptions leave the next slot alive
			squash_d = is_jump && !rsp_d.misaligned && !rsp_d.fetch_fault;
		end
	end

	always_comb begin
		rsp_d             = '0;
		rsp_d.valid       = live;
		rsp_d.dest_reg    = dest_reg;
		// Only the all-zero immediate form is the canonical no-op
		rsp_d.is_nop      = live && (req.insn == {12'h000, iaj_pkg::REG_ZERO, iaj_pkg::F3_SUM,
			iaj_pkg::REG_ZERO, iaj_pkg::OPC_IMM});
		// Zero destination never written; no-op writes nothing
		rsp_d.wr_en       = live && writes && (dest_reg != iaj_pkg::REG_ZERO);
		rsp_d.wr_data     = rsp_d.wr_en ? result : 32'h0000_0000;
		rsp_d.redirect    = live && is_jump;
		rsp_d.target      = target;
		// Misaligned only without halfword support
		rsp_d.misaligned  = live && is_jump && !HALF_ALIGNED && (target[1:0] != 2'h0);
		rsp_d.illegal     = live && (op == iaj_pkg::IAJ_OP_ILLEGAL);
		rsp_d.ras_push    = live && ras_push && !rsp_d.misaligned;
		rsp_d.ras_pop     = live && ras_pop && !rsp_d.misaligned;
		// Fetch fault belongs to the arriving instruction
		rsp_d.fetch_fault = live && req.fetch_fault;
		rsp_d.exc_pc      = req.pc;
		if (rsp_d.misaligned || rsp_d.illegal || rsp_d.fetch_fault) begin
			rsp_d.wr_en    = 1'b0;
			rsp_d.wr_data  = 32'h0000_0000;
			rsp_d.redirect = 1'b0;
			rsp_d.ras_push = 1'b0;
			rsp_d.ras_pop  = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rsp_q    <= '0;
			squash_q <= 1'b0;
		end else begin
			rsp_q    <= rsp_d;
			squash_q <= squash_d;
		end
	end

	assign rsp = rsp_q;
endmodule
`default_nettype wire

// ### iaj_unit_properties.sv
// Property checker for the ALU and jump unit
`timescale 1ns/1ps
`default_nettype none
module iaj_unit_check (
	input wire logic              clock,
	input wire logic              rst_n,
	input wire iaj_pkg::iaj_req_t req,
	input wire iaj_pkg::iaj_rsp_t rsp
);
	logic       go;
	logic       rb;
	logic       ra;
	logic [2:0] f3;
	assign f3 = req.insn[14:12];
	assign go = req.valid && !req.fetch_fault && req.insn[11:7] != 5'h00;
	assign rb = go && req.insn[6:0] == iaj_pkg::OPC_REG && req.insn[31:25] == 7'h00;
	assign ra = go && req.insn[6:0] == iaj_pkg::OPC_REG && req.insn[31:25] == 7'h20;
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	a_sum_result: assert property (rb && f3 == 3'h0 |=>
		!rsp.valid || rsp.wr_data == $past(req.src1) + $past(req.src2)) else $error("sum");
	a_diff_result: assert property (ra && f3 == 3'h0 |=>
		!rsp.valid || rsp.wr_data == $past(req.src1) - $past(req.src2)) else $error("diff");
	a_uless_result: assert property (rb && f3 == 3'h3 |=>
		!rsp.valid || rsp.wr_data == {31'h0, $past(req.src1) < $past(req.src2)}) else $error("less");
	a_xor_result: assert property (rb && f3 == 3'h4 |=>
		!rsp.valid || rsp.wr_data == ($past(req.src1) ^ $past(req.src2))) else $error("xor");
	a_shift_amount: assert property (rb && f3 == 3'h1 |=>
		!rsp.valid || rsp.wr_data == $past(req.src1) << $past(req.src2[4:0])) else $error("shl");
	a_pc_link: assert property (go && req.insn[6:0] == iaj_pkg::OPC_JUMP |=>
		!rsp.valid || rsp.misaligned || rsp.wr_data == $past(req.pc) + 32'h4) else $error("link");
	a_ind_target: assert property (go && req.insn[6:0] == iaj_pkg::OPC_IND_JUMP && f3 == 3'h0 |=>
		!rsp.valid || rsp.misaligned || rsp.target == (($past(req.src1)
		+ {{20{$past(req.insn[31])}}, $past(req.insn[31:20])}) & ~32'h1)) else $error("ind");
	a_squash_slot: assert property (rsp.redirect |=> !rsp.valid) else $error("slot");
	a_zero_discard: assert property (rsp.wr_en |-> rsp.dest_reg != 5'h00) else $error("x0");
	a_nop_quiet: assert property (rsp.is_nop |-> !rsp.wr_en && !rsp.redirect) else $error("nop");
	cover property (rsp.redirect && rsp.ras_push);
	cover property (rsp.ras_push && rsp.ras_pop);
	cover property (rsp.misaligned);
endmodule
bind iaj_unit iaj_unit_check iaj_unit_check_i (.clock(clock), .rst_n(rst_n), .req(req), .rsp(rsp));
`default_nettype wire

// ### iaj_unit_tb.sv
// Self-checking testbench for the ALU and jump unit
`timescale 1ns/1ps
`default_nettype none
module iaj_unit_tb;
	logic              clock;
	logic              rst_n;
	iaj_pkg::iaj_req_t req;
	iaj_pkg::iaj_rsp_t rsp;
	iaj_pkg::iaj_rsp_t rsp_half;
	int                fail_count;
	int                total_checks;
	iaj_unit iaj_unit_i (.clock(clock), .rst_n(rst_n), .req(req), .rsp(rsp));
	iaj_unit #(.HALF_ALIGNED(1'b1)) iaj_unit_half_i (
		.clock (clock),
		.rst_n (rst_n),
		.req   (req),
		.rsp   (rsp_half)
	);
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	function automatic logic [31:0] rt(logic [6:0] u, logic [2:0] f, logic [4:0] d);
		return {u, 5'h02, 5'h01, f, d, 7'h33};
	endfunction
	function automatic logic [31:0] jt(logic [20:0] m, logic [4:0] d);
		return {m[20], m[10:1], m[11], m[19:12], d, 7'h6F};
	endfunction
	function automatic logic [31:0] it(logic [11:0] m, logic [4:0] s, logic [4:0] d, logic [6:0] o);
		return {m, s, 3'h0, d, o};
	endfunction
	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		total_checks++;
		if (g !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic put(logic [31:0] i, logic [31:0] pc, logic [31:0] a, logic [31:0] b, logic f);
		@(posedge clock);
		req <= '{1'b1, pc, i, a, b, f};
	endtask
	task automatic op(logic [31:0] i, logic [31:0] pc, logic [31:0] a, logic [31:0] b, logic f);
		put(i, pc, a, b, f);
		@(posedge clock);
		req.valid <= 1'b0;
		#1;
	endtask
	task automatic final_report;
		if (fail_count == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic t_alu;
		logic [31:0] e [10] = '{32'h8000_0028, 32'h7FFF_FFDE, 32'h0000_0060, 32'h1, 32'h0,
			32'h8000_0026, 32'h0400_0000, 32'hFC00_0000, 32'h8000_0027, 32'h1};
		logic [6:0]  u [10] = '{7'h00, 7'h20, 7'h00, 7'h00, 7'h00, 7'h00, 7'h00, 7'h20, 7'h00, 7'h00};
		logic [2:0]  f [10] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h5, 3'h5, 3'h6, 3'h7};
		for (int k = 0; k < 10; k++) begin
			op(rt(u[k], f[k], 5'h0A), 32'h40, 32'h8000_0003, 32'h0000_0025, 1'b0);
			chk("alu", e[k], rsp.wr_data);
			chk("dest", 32'h2A, {26'h0, rsp.wr_en, rsp.dest_reg});
		end
	endtask
	task automatic t_misc;
		op(32'h0000_0013, 32'h0, 32'h5, 32'h0, 1'b0);
		chk("nop", 32'h1, {30'h0, rsp.wr_en, rsp.is_nop});
		op(it(12'h001, 5'h00, 5'h00, 7'h13), 32'hC, 32'h0, 32'h0, 1'b0);
		chk("nopimm", 32'h0, {31'h0, rsp.is_nop});
		op(rt(7'h01, 3'h0, 5'h0A), 32'h10, 32'h1, 32'h2, 1'b0);
		chk("ill", 32'h2, {30'h0, rsp.illegal, rsp.wr_en});
		op(it(12'hFFF, 5'h01, 5'h03, 7'h13), 32'h4, 32'h5, 32'h0, 1'b0);
		chk("imm", 32'h4, rsp.wr_data);
		op(rt(7'h00, 3'h0, 5'h00), 32'h8, 32'h1, 32'h2, 1'b0);
		chk("zero", 32'h0, {31'h0, rsp.wr_en});
	endtask
	task automatic t_jump;
		logic [4:0] d [2] = '{5'h05, 5'h06};
		put(jt(21'h1F_FFF8, 5'h01), 32'h100, 32'h0, 32'h0, 1'b0);
		put(rt(7'h00, 3'h0, 5'h02), 32'h104, 32'h1, 32'h1, 1'b0);
		#1;
		chk("link", 32'h104, rsp.wr_data);
		chk("tgt", 32'hF8, rsp.target);
		chk("push", 32'h3, {30'h0, rsp.redirect, rsp.ras_push});
		@(posedge clock);
		req.valid <= 1'b0;
		#1;
		chk("slot", 32'h0, {31'h0, rsp.valid});
		for (int k = 0; k < 2; k++) begin
			op(jt(21'h8, d[k]), 32'h100, 32'h0, 32'h0, 1'b0);
			chk("hint", {31'h0, k == 0}, {31'h0, rsp.ras_push});
		end
	endtask
	task automatic t_ind;
		logic [4:0] d [5] = '{5'h00, 5'h00, 5'h01, 5'h05, 5'h01};
		logic [4:0] s [5] = '{5'h00, 5'h01, 5'h00, 5'h01, 5'h01};
		logic [1:0] h [5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h2};
		for (int k = 0; k < 5; k++) begin
			op(it(12'h002, s[k], d[k], 7'h67), 32'h300, 32'h1FF, 32'h0, 1'b0);
			chk("itgt", 32'h200, rsp.target);
			chk("ras", {30'h0, h[k]}, {30'h0, rsp.ras_push, rsp.ras_pop});
			chk("ilnk", d[k] != 5'h00 ? 32'h304 : 32'h0, rsp.wr_data);
		end
	endtask
	task automatic t_fault;
		op(jt(21'h2, 5'h01), 32'h100, 32'h0, 32'h0, 1'b0);
		chk("mis", 32'h1, {31'h0, rsp.misaligned});
		chk("mpc", 32'h100, rsp.exc_pc);
		chk("half", 32'h2, {30'h0, rsp_half.redirect, rsp_half.misaligned});
		op(jt(21'h10, 5'h00), 32'h200, 32'h0, 32'h0, 1'b0);
		chk("jflt", 32'h0, {31'h0, rsp.fetch_fault});
		op(32'h0000_0013, 32'h210, 32'h0, 32'h0, 1'b1);
		chk("flt", 32'h1, {31'h0, rsp.fetch_fault});
		chk("fpc", 32'h210, rsp.exc_pc);
		op(jt(21'h8, 5'h01), 32'h220, 32'h0, 32'h0, 1'b1);
		chk("fjmp", 32'h0, {30'h0, rsp.redirect, rsp.ras_push});
	endtask
	initial begin
		rst_n = 1'b0;
		req = '0;
		fail_count = 0;
		total_checks = 0;
		repeat (8) @(posedge clock);
		rst_n <= 1'b1;
		t_alu;
		t_misc;
		t_jump;
		t_ind;
		t_fault;
		final_report;
	end
	initial begin
		repeat (1000) @(posedge clock);
		fail_count++;
		final_report;
	end
endmodule
`default_nettype wire
